// ---- pixwin_pkg.sv ----
/*
  Constants and carrier types for the pixel shift and window output block.
  Assumes one Avalon-MM register port on the system clock and a separate
  pixel clock that carries converter samples and the outgoing pixel words.
*/
// Contract
// - 10-bit mode, no shift: send each sample unchanged.
// - 10-bit mode, shift once: sample bits 8..0 then one zero.
// - 10-bit mode, shift twice: sample bits 7..0 then two zeros.
// - 10-bit mode, shift three times: bits 6..0 then three zeros.
// - Any set bit shifted off the top forces all output bits to one.
// - 8-bit mode, no shift: output sample bits 9..2.
// - 8-bit mode, shift once: output sample bits 8..1.
// - 8-bit mode, shift twice: output sample bits 7..0.
// - 8-bit mode, shift three times: bits 6..0 then one zero.
// - Send only pixels start through start plus length minus one.
// - Line valid rises with the first window pixel.
// - Line valid drops once the last window pixel has gone.
// - Start 1 with length 2098 sends the whole array.
// - A smaller window never shortens the line period.
// - Same shift applies to red, green and blue lines.
package pixwin_pkg;

  // ----------------------------------------------------------------
  // Widths and array size
  // ----------------------------------------------------------------
  localparam int SAMPLE_W = 10;
  localparam int POS_W = 12;
  localparam logic [POS_W-1:0] FIRST_PIXEL = 12'h001;
  localparam logic [POS_W-1:0] ARRAY_PIXELS = 12'h832; // 2098 pixels
  localparam logic [POS_W-1:0] POS_MAX = 12'hfff;

  // ----------------------------------------------------------------
  // Register byte offsets and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_WIN_START = 4'h4;
  localparam logic [3:0] REG_WIN_LEN = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;
  localparam int CTRL_SHIFT_LSB = 0;
  localparam int CTRL_MODE8_BIT = 2;
  localparam int STATUS_PENDING_BIT = 0;
  localparam int STATUS_LINE_BIT = 1;

  // ----------------------------------------------------------------
  // Modes and carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SHIFT_NONE = 2'h0,
    SHIFT_ONCE = 2'h1,
    SHIFT_TWICE = 2'h2,
    SHIFT_THRICE = 2'h3
  } shift_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] red;
    logic [SAMPLE_W-1:0] green;
    logic [SAMPLE_W-1:0] blue;
  } rgb_t;

  typedef struct packed {
    logic mode8;
    shift_t shift;
    logic [POS_W-1:0] win_start;
    logic [POS_W-1:0] win_len;
  } cfg_t;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam cfg_t CFG_RESET = '{mode8: 1'b0, shift: SHIFT_NONE,
                                 win_start: FIRST_PIXEL, win_len: ARRAY_PIXELS};

endpackage : pixwin_pkg

// ---- pixel_shift_window.sv ----
/*
  Pixel output formatter: digital shift with saturation, 8/10-bit packing
  and a per-line pixel window driving line valid. Registers sit on the
  system clock; the pixel path runs on pix_clk. Settings cross by a toggle
  handshake. Assumes samples, px_valid and px_first come from logic on
  pix_clk and that px_first marks pixel 1 of every line.
*/
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps
module pixel_shift_window (
  // System clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Avalon-MM register slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Converter samples on the pixel clock
  input wire logic pix_clk,
  input wire logic px_valid,
  input wire logic px_first,
  input wire pixwin_pkg::rgb_t px_in,
  // Pixel words to the frame grabber
  output pixwin_pkg::rgb_t out_px,
  output logic line_valid
);

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic served;
    logic [31:0] rdata;
    pixwin_pkg::cfg_t cfg;
    pixwin_pkg::cfg_t hold;
    logic dirty;
    logic req_tgl;
    logic ack_s1;
    logic ack_s2;
    logic lv_s1;
    logic lv_s2;
  } sys_state_t;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic ack_tgl;
    pixwin_pkg::cfg_t cfg;
    logic [pixwin_pkg::POS_W-1:0] idx;
    pixwin_pkg::rgb_t out;
    logic lv;
  } pix_state_t;

  sys_state_t s;
  sys_state_t next_s;
  pix_state_t p;
  pix_state_t next_p;

  // ----------------------------------------------------------------
  // Shift and pack one sample
  // ----------------------------------------------------------------
  function automatic logic [9:0] shift_pix(input logic [9:0] smp, input logic mode8,
                                           input pixwin_pkg::shift_t sh);
    logic ovf;
    logic [9:0] w;
    case (sh)
      pixwin_pkg::SHIFT_ONCE: begin
        ovf = smp[9];
        w = {smp[8:0], 1'b0};
      end
      pixwin_pkg::SHIFT_TWICE: begin
        ovf = |smp[9:8];
        w = {smp[7:0], 2'h0};
      end
      pixwin_pkg::SHIFT_THRICE: begin
        ovf = |smp[9:7];
        w = {smp[6:0], 3'h0};
      end
      default: begin
        ovf = 1'b0;
        w = smp;
      end
    endcase
    // 8-bit words keep the top eight bits of the shifted value
    if (mode8) begin
      shift_pix = {2'h0, (ovf ? 8'hff : w[9:2])};
    end else begin
      shift_pix = ovf ? 10'h3ff : w;
    end
  endfunction : shift_pix

  // ----------------------------------------------------------------
  // Register slave: one wait cycle per access
  // ----------------------------------------------------------------
  logic req_any;
  logic write_now;
  assign req_any = avs_read | avs_write;
  assign write_now = avs_write & s.served;
  assign avs_waitrequest = req_any & ~s.served;
  assign avs_readdata = s.rdata;

  // System clock next state
  always_comb begin
    next_s = s;
    next_s.ack_s1 = p.ack_tgl;
    next_s.ack_s2 = s.ack_s1;
    next_s.lv_s1 = p.lv;
    next_s.lv_s2 = s.lv_s1;
    next_s.served = req_any & ~s.served;
    // Read data is caught in the wait cycle so it stands at the release edge
    if (avs_read && !s.served) begin
      case (avs_address)
        pixwin_pkg::REG_CTRL: begin
          next_s.rdata = 32'h0;
          next_s.rdata[pixwin_pkg::CTRL_SHIFT_LSB +: 2] = s.cfg.shift;
          next_s.rdata[pixwin_pkg::CTRL_MODE8_BIT] = s.cfg.mode8;
        end
        pixwin_pkg::REG_WIN_START: begin
          next_s.rdata = {20'h0, s.cfg.win_start};
        end
        pixwin_pkg::REG_WIN_LEN: begin
          next_s.rdata = {20'h0, s.cfg.win_len};
        end
        pixwin_pkg::REG_STATUS: begin
          next_s.rdata = 32'h0;
          next_s.rdata[pixwin_pkg::STATUS_PENDING_BIT] = s.dirty | (s.req_tgl ^ s.ack_s2);
          next_s.rdata[pixwin_pkg::STATUS_LINE_BIT] = s.lv_s2;
        end
        default: begin
          next_s.rdata = 32'h0; // Unmapped reads return zero
        end
      endcase
    end
    // Launch a settings transfer when the last one is acknowledged
    if (s.dirty && (s.req_tgl == s.ack_s2)) begin
      next_s.hold = s.cfg;
      next_s.req_tgl = ~s.req_tgl;
      next_s.dirty = 1'b0;
    end
    // A write in the launch cycle keeps dirty set, so it is never lost
    if (write_now) begin
      case (avs_address)
        pixwin_pkg::REG_CTRL: begin
          next_s.cfg.shift = pixwin_pkg::shift_t'(avs_writedata[pixwin_pkg::CTRL_SHIFT_LSB +: 2]);
          next_s.cfg.mode8 = avs_writedata[pixwin_pkg::CTRL_MODE8_BIT];
          next_s.dirty = 1'b1;
        end
        pixwin_pkg::REG_WIN_START: begin
          next_s.cfg.win_start = avs_writedata[pixwin_pkg::POS_W-1:0];
          next_s.dirty = 1'b1;
        end
        pixwin_pkg::REG_WIN_LEN: begin
          next_s.cfg.win_len = avs_writedata[pixwin_pkg::POS_W-1:0];
          next_s.dirty = 1'b1;
        end
        default: begin
          next_s.dirty = next_s.dirty; // Status and holes ignore writes
        end
      endcase
    end
    if (!reset_n) begin
      next_s = '0;
      next_s.cfg = pixwin_pkg::CFG_RESET;
      next_s.hold = pixwin_pkg::CFG_RESET;
    end
  end

  // System clock registers
  always_ff @(posedge clk) begin
    s <= next_s;
  end

  // ----------------------------------------------------------------
  // Pixel path
  // ----------------------------------------------------------------
  logic [pixwin_pkg::POS_W-1:0] cur_idx;
  logic [pixwin_pkg::POS_W-1:0] start_eff;
  logic [pixwin_pkg::POS_W:0] last_sum;
  logic [pixwin_pkg::POS_W-1:0] last_eff;
  logic in_win;

  // Window bounds: start 0 acts as 1, end never passes the array
  always_comb begin
    if (px_first) begin
      cur_idx = pixwin_pkg::FIRST_PIXEL;
    end else if (p.idx == pixwin_pkg::POS_MAX) begin
      cur_idx = p.idx; // Hold rather than wrap into the window again
    end else begin
      cur_idx = p.idx + pixwin_pkg::FIRST_PIXEL;
    end
    start_eff = (p.cfg.win_start == 12'h000) ? pixwin_pkg::FIRST_PIXEL : p.cfg.win_start;
    last_sum = {1'b0, start_eff} + {1'b0, p.cfg.win_len} - 13'h0001;
    if (last_sum > {1'b0, pixwin_pkg::ARRAY_PIXELS}) begin
      last_eff = pixwin_pkg::ARRAY_PIXELS;
    end else begin
      last_eff = last_sum[pixwin_pkg::POS_W-1:0];
    end
    in_win = px_valid && (p.cfg.win_len != 12'h000) && (cur_idx >= start_eff)
             && (cur_idx <= last_eff);
  end

  // Pixel clock next state
  always_comb begin
    next_p = p;
    next_p.rst_s1 = reset_n;
    next_p.rst_s2 = p.rst_s1;
    next_p.req_s1 = s.req_tgl;
    next_p.req_s2 = p.req_s1;
    next_p.req_s3 = p.req_s2;
    // New settings take effect between pixels; hold is stable until acked
    if (p.req_s2 != p.req_s3) begin
      next_p.cfg = s.hold;
      next_p.ack_tgl = p.req_s2;
    end
    if (px_valid) begin
      next_p.idx = cur_idx;
    end
    // Output cadence follows the input one for one, window or not
    next_p.lv = in_win;
    if (in_win) begin
      next_p.out.red = shift_pix(px_in.red, p.cfg.mode8, p.cfg.shift);
      next_p.out.green = shift_pix(px_in.green, p.cfg.mode8, p.cfg.shift);
      next_p.out.blue = shift_pix(px_in.blue, p.cfg.mode8, p.cfg.shift);
    end else begin
      next_p.out = '0;
    end
    if (!p.rst_s2) begin
      next_p = '0;
      next_p.rst_s1 = reset_n;
      next_p.rst_s2 = p.rst_s1;
      next_p.cfg = pixwin_pkg::CFG_RESET;
    end
  end

  // Pixel clock registers
  always_ff @(posedge pix_clk) begin
    p <= next_p;
  end

  assign out_px = p.out;
  assign line_valid = p.lv;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [9:0] smp_r;
  logic [9:0] smp_g;
  logic [9:0] smp_b;
  logic ten_mode;
  pixwin_pkg::shift_t cur_sh;
  assign smp_r = px_in.red;
  assign smp_g = px_in.green;
  assign smp_b = px_in.blue;
  assign ten_mode = ~p.cfg.mode8;
  assign cur_sh = p.cfg.shift;

  AST_TEN_NOSHIFT: assert property (@(posedge pix_clk) disable iff (!p.rst_s2)
    in_win && ten_mode && cur_sh == pixwin_pkg::SHIFT_NONE |=> out_px.red == $past(smp_r))
    else $error("10-bit unshifted word differs from sample");
  AST_TEN_ONCE: assert property (@(posedge pix_clk) disable iff (!p.rst_s2)
    in_win && ten_mode && cur_sh == pixwin_pkg::SHIFT_ONCE && !smp_r[9]
    |=> out_px.red == {$past(smp_r[8:0]), 1'b0})
    else $error("10-bit shift once word wrong");
  AST_TEN_TWICE: assert property (@(posedge pix_clk) disable iff (!p.rst_s2)
    in_win && ten_mode && cur_sh == pixwin_pkg::SHIFT_TWICE && smp_r[9:8] == 2'h0
    |=> out_px.red[1:0] == 2'h0 && out_px.red[9:2] == $past(smp_r[7:0]))
    else $error("10-bit shift twice word wrong");
  AST_TEN_THRICE: assert property (@(posedge pix_clk) disable iff (!p.rst_s2)
    in_win && ten_mode && cur_sh == pixwin_pkg::SHIFT_THRICE && smp_r[9:7] == 3'h0
    |=> out_px.red == {$past(smp_r[6:0]), 3'h0})
    else $error("10-bit shift three times word wrong");
  AST_SATURATE: assert property (@(posedge pix_clk) disable iff (!p.rst_s2)
    in_win && cur_sh == pixwin_pkg::SHIFT_TWICE && smp_g[8]
    |=> out_px.green == ($past(ten_mode) ? 10'h3ff : 10'h0ff))
    else $error("Overflow did not saturate");
  AST_EIGHT_NOSHIFT: assert property (@(posedge pix_clk) disable iff (!p.rst_s2)
    in_win && !ten_mode && cur_sh == pixwin_pkg::SHIFT_NONE
    |=> out_px.blue == {2'h0, $past(smp_b[9:2])})
    else $error("8-bit unshifted byte wrong");
  AST_EIGHT_ONCE: assert property (@(posedge pix_clk) disable iff (!p.rst_s2)
    in_win && !ten_mode && cur_sh == pixwin_pkg::SHIFT_ONCE && !smp_b[9]
    |=> out_px.blue == {2'h0, $past(smp_b[8:1])})
    else $error("8-bit shift once byte wrong");
  AST_EIGHT_TWICE: assert property (@(posedge pix_clk) disable iff (!p.rst_s2)
    in_win && !ten_mode && cur_sh == pixwin_pkg::SHIFT_TWICE && smp_b[9:8] == 2'h0
    |=> out_px.blue[7:0] == $past(smp_b[7:0]))
    else $error("8-bit shift twice byte wrong");
  AST_EIGHT_THRICE: assert property (@(posedge pix_clk) disable iff (!p.rst_s2)
    in_win && !ten_mode && cur_sh == pixwin_pkg::SHIFT_THRICE && smp_b[9:7] == 3'h0
    |=> out_px.blue == {2'h0, $past(smp_b[6:0]), 1'b0})
    else $error("8-bit shift three times byte wrong");
  AST_DROP_OUTSIDE: assert property (@(posedge pix_clk) disable iff (!p.rst_s2)
    !in_win |=> !line_valid && out_px == '0)
    else $error("Pixel outside window was sent");
  AST_LV_RISE: assert property (@(posedge pix_clk) disable iff (!p.rst_s2)
    px_valid && cur_idx == start_eff && start_eff <= last_eff
    && p.cfg.win_len != 12'h000 |=> line_valid)
    else $error("Line valid missing on first window pixel");
  AST_LV_FALL: assert property (@(posedge pix_clk) disable iff (!p.rst_s2)
    in_win && cur_idx == last_eff ##1 px_valid && !px_first |=> !line_valid)
    else $error("Line valid stayed high past window end");
  AST_FULL_ARRAY: assert property (@(posedge pix_clk) disable iff (!p.rst_s2)
    px_valid && p.cfg.win_start == pixwin_pkg::FIRST_PIXEL
    && p.cfg.win_len == pixwin_pkg::ARRAY_PIXELS && cur_idx <= pixwin_pkg::ARRAY_PIXELS
    |=> line_valid)
    else $error("Full array setting dropped a pixel");
  AST_SAME_CADENCE: assert property (@(posedge pix_clk) disable iff (!p.rst_s2)
    line_valid |-> $past(px_valid))
    else $error("Output word without an input sample");
  AST_COLOURS_MATCH: assert property (@(posedge pix_clk) disable iff (!p.rst_s2)
    in_win && smp_r == smp_g && smp_g == smp_b
    |=> out_px.red == out_px.green && out_px.green == out_px.blue)
    else $error("Colour lines shifted differently");
  AST_ARRAY_END: assert property (@(posedge pix_clk) disable iff (!p.rst_s2)
    line_valid |-> $past(cur_idx) <= pixwin_pkg::ARRAY_PIXELS)
    else $error("Pixel beyond array end was sent");

endmodule : pixel_shift_window

// ---- pixwin_grabber.sv ----
/*
  Frame grabber model for the pixel formatter: it collects every pixel word
  seen while line valid is high and measures each line at its falling edge.
  Assumes out_px and line_valid are registered on pix_clk.
*/
`timescale 1ns/100ps
module pixwin_grabber (
  // Pixel clock
  input wire logic pix_clk,
  // Pixel words from the formatter
  input wire pixwin_pkg::rgb_t px_word,
  input wire logic line_valid
);
  // ----------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------
  pixwin_pkg::rgb_t words[$];
  int run_len = 0;
  int last_len = 0;
  int stray = 0;
  logic lv_d = 1'b0;

  // Length is taken at the fall, as a grabber that trusts line valid does
  always @(posedge pix_clk) begin
    if (line_valid === 1'b1) begin
      words.push_back(px_word);
      run_len = run_len + 1;
    end else if (px_word !== '0) begin
      stray = stray + 1; // Dropped pixels must not leak onto the wire
    end
    if (lv_d === 1'b1 && line_valid !== 1'b1) begin
      last_len = run_len;
      run_len = 0;
    end
    lv_d = line_valid;
  end
endmodule : pixwin_grabber

// ---- testbench.sv ----
/*
  Self-checking bench for the pixel shift and window formatter.
  Assumes the design settles register writes into the pixel domain and
  reports that through the pending bit of the status register.
*/
`timescale 1ns/100ps
module testbench;
  // ----------------------------------------------------------------
  // Signals and clocks
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic pix_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic px_valid = 1'b0;
  logic px_first = 1'b0;
  pixwin_pkg::rgb_t px_in = '0;
  pixwin_pkg::rgb_t out_px;
  logic line_valid;
  int bad_count = 0;
  int checked = 0;
  logic [31:0] rd;
  logic [31:0] ew;
  logic [31:0] sv;
  // Samples hit every overflow bit and plain values for each shift
  logic [9:0] tab [0:7] = '{10'h3ff, 10'h200, 10'h155, 10'h07f,
                            10'h100, 10'h0aa, 10'h080, 10'h001};
  logic [3:0] ra [0:4] = '{pixwin_pkg::REG_CTRL, pixwin_pkg::REG_WIN_START,
                           pixwin_pkg::REG_WIN_LEN, pixwin_pkg::REG_STATUS, 4'h2};
  logic [31:0] rv [0:4] = '{32'h0, 32'h1, {20'h0, pixwin_pkg::ARRAY_PIXELS}, 32'h0, 32'h0};
  int ws [0:1] = '{2090, 1};
  int wl [0:1] = '{20, 2098};
  int wn [0:1] = '{9, 2098};

  // Rising edges of the two clocks never coincide (40 ns against 48 ns)
  always #20 clk = ~clk;
  always #24 pix_clk = ~pix_clk;

  pixel_shift_window uut (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pix_clk(pix_clk), .px_valid(px_valid),
    .px_first(px_first), .px_in(px_in), .out_px(out_px), .line_valid(line_valid)
  );

  pixwin_grabber grab (.pix_clk(pix_clk), .px_word(out_px), .line_valid(line_valid));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task final_report;
    if (bad_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  // One bus cycle; held until waitrequest is seen low at a rising edge
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_write <= wr;
    avs_read <= ~wr;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 20) check({31'h0, avs_waitrequest}, 32'h0);
  endtask : bus

  // Polls until the settings have reached the pixel domain
  task settle;
    int n;
    n = 0;
    do begin
      bus(1'b0, pixwin_pkg::REG_STATUS, 32'h0);
      n++;
    end while (rd[pixwin_pkg::STATUS_PENDING_BIT] !== 1'b0 && n < 40);
    check({31'h0, rd[pixwin_pkg::STATUS_PENDING_BIT]}, 32'h0);
  endtask : settle

  function automatic pixwin_pkg::rgb_t pix(input int i);
    return '{red: tab[i % 8], green: tab[(i + 3) % 8], blue: tab[(i + 5) % 8]};
  endfunction : pix

  // Shift by building the wide word; any bit above the top saturates
  function automatic logic [9:0] fmt(input logic [9:0] s, input logic m8, input logic [1:0] sh);
    logic [12:0] v;
    v = {3'h0, s} << sh;
    if (|v[12:10]) return m8 ? 10'h0ff : 10'h3ff;
    return m8 ? {2'h0, v[9:2]} : v[9:0];
  endfunction : fmt

  function automatic logic [31:0] exp_word(input int i, input logic m8, input logic [1:0] sh);
    pixwin_pkg::rgb_t p;
    p = pix(i);
    return {2'h0, fmt(p.red, m8, sh), fmt(p.green, m8, sh), fmt(p.blue, m8, sh)};
  endfunction : exp_word

  task send_line(input int n);
    for (int i = 1; i <= n; i++) begin
      @(posedge pix_clk);
      px_valid <= 1'b1;
      px_first <= (i == 1);
      px_in <= pix(i);
    end
  endtask : send_line

  // Idle samples carry junk so a stale value cannot pass for a pixel
  task idle;
    @(posedge pix_clk);
    px_valid <= 1'b0;
    px_first <= 1'b0;
    px_in <= ~px_in;
    repeat (6) @(posedge pix_clk);
  endtask : idle

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    // Reset values, then an unmapped address
    for (int k = 0; k < 5; k++) begin
      bus(1'b0, ra[k], 32'h0);
      check(rd, rv[k]);
    end
    // Every width and shift on the same samples for all three colours
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 4; s++) begin
        bus(1'b1, pixwin_pkg::REG_CTRL, 32'(m * 4 + s));
        settle();
        grab.words.delete();
        send_line(8);
        idle();
        check(32'(grab.words.size()), 32'h8);
        for (int k = 0; k < 8; k++) begin
          ew = exp_word(k + 1, m[0], s[1:0]);
          if (m == 0) check({2'h0, grab.words[k]}, ew);
          else check({2'h0, grab.words[k]}, ew);
          // Guided shifts never saturate: the reading only scales up
          sv = 32'(tab[(k + 1) % 8]);
          if (s > 0 && (sv >> (2 * m)) < (32'h400 >> (2 * m + s))) begin
            if (m == 0) check(32'(grab.words[k].red), sv << s);
            else check(32'(grab.words[k].red), (sv << s) >> 2);
          end
        end
      end
    end
    // Window 10..24 on two lines sent back to back
    bus(1'b1, pixwin_pkg::REG_CTRL, 32'h0);
    bus(1'b1, pixwin_pkg::REG_WIN_START, 32'd10);
    bus(1'b1, pixwin_pkg::REG_WIN_LEN, 32'd15);
    settle();
    grab.words.delete();
    grab.stray = 0;
    send_line(30);
    send_line(30);
    idle();
    check(32'(grab.words.size()), 32'd30);
    check(32'(grab.last_len), 32'd15);
    check({2'h0, grab.words[0]}, exp_word(10, 1'b0, 2'h0));
    check({2'h0, grab.words[14]}, exp_word(24, 1'b0, 2'h0));
    check({2'h0, grab.words[15]}, exp_word(10, 1'b0, 2'h0));
    check(32'(grab.stray), 32'h0);
    // Window running past the array end, then the full array
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, pixwin_pkg::REG_WIN_START, 32'(ws[k]));
      bus(1'b1, pixwin_pkg::REG_WIN_LEN, 32'(wl[k]));
      settle();
      grab.words.delete();
      // Status line bit is read mid-line, well before the narrow window opens
      fork
        send_line(2100);
        begin
          repeat (100) @(posedge clk);
          bus(1'b0, pixwin_pkg::REG_STATUS, 32'h0);
        end
      join
      check({31'h0, rd[pixwin_pkg::STATUS_LINE_BIT]}, 32'(k));
      idle();
      check(32'(grab.words.size()), 32'(wn[k]));
      check({2'h0, grab.words[0]}, exp_word(ws[k], 1'b0, 2'h0));
      check({2'h0, grab.words[wn[k] - 1]}, exp_word(2098, 1'b0, 2'h0));
    end
    final_report();
  end

  // Hang guard: the run needs well under half a millisecond
  initial begin
    #2000000;
    bad_count++;
    final_report();
  end
endmodule : testbench
